//--- arce_pkg.sv
// Constants, opcodes, error codes and state encoding for the read command engine.
// Assumes one device clock and a task file held outside this block.
// What this block does
// [RULE1] C4H moves sectors in blocks and interrupts once per block.
// [RULE2] Supported multiple block count is limited to one, shown in identify data.
// [RULE3] Block reads qualify data request only at the start of each block.
// [RULE4] Sector count counts sectors; last partial block holds the remainder.
// [RULE5] Block read aborts without prior set-multiple or when block mode is disabled.
// [RULE6] Media error in a block read is posted at block start; block still moves.
// [RULE7] Block read interrupt fires as data request rises at each block start.
// [RULE8] Sector reads move one to 256 sectors, count zero meaning 256.
// [RULE9] Only a correctable error lets a block read continue past the block.
// [RULE10] Sector read loads each sector, raises data request, drops busy, interrupts.
// [RULE11] Successful read leaves the last sector address in the task file.
// [RULE12] Read error stops at the failing sector, reports its address, keeps data.
// [RULE13] Long read returns 516 bytes, single sector, with no error check.
// [RULE14] Long read carries 256 data words, then four correction bytes.
// [RULE15] Native max address is spread over head, cylinder and sector registers.
// [RULE16] Native max address equals the factory highest accepted address.
// [RULE17] Verify sets busy, never raises data request, then clears busy and interrupts.
// [RULE18] Failed verify reports failing sector and leaves the unverified count.
// [RULE19] Any 1XH opcode is accepted as recalibrate and does nothing.
// [RULE20] Request sense puts the previous extended error code in the error register.
// [RULE21] Host should avoid the long read in normal use.
// [RULE22] Extended codes: 1FH aborted, 11H uncorrectable, 18H corrected.
// [RULE23] Recalibrate finishes with busy clear, no error and an interrupt.
`default_nettype none
package arce_pkg;
	localparam logic [7:0] OP_READ_MULTI  = 8'hC4;
	localparam logic [7:0] OP_READ_SEC0   = 8'h20;
	localparam logic [7:0] OP_READ_SEC1   = 8'h21;
	localparam logic [7:0] OP_READ_LONG0  = 8'h22;
	localparam logic [7:0] OP_READ_LONG1  = 8'h23;
	localparam logic [7:0] OP_NATIVE_MAX  = 8'hF8;
	localparam logic [7:0] OP_VERIFY0     = 8'h40;
	localparam logic [7:0] OP_VERIFY1     = 8'h41;
	localparam logic [3:0] OP_RECAL_HI    = 4'h1;
	localparam logic [7:0] OP_SENSE       = 8'h03;
	localparam logic [7:0] XERR_NONE      = 8'h00;
	localparam logic [7:0] XERR_ABORT     = 8'h1F;
	localparam logic [7:0] XERR_UNCORR    = 8'h11;
	localparam logic [7:0] XERR_CORR      = 8'h18;
	localparam logic [7:0] XERR_INVALID   = 8'h20;
	localparam logic [7:0] ERR_BIT_ABRT   = 8'h04;
	localparam logic [7:0] ERR_BIT_UNC    = 8'h40;
	localparam logic [7:0] MAX_BLOCK      = 8'h01;
	localparam logic [8:0] SEC_FULL       = 9'h100;
	localparam logic [8:0] WORDS_PER_SEC  = 9'h100;
	localparam logic [2:0] ECC_BYTES      = 3'h4;
	localparam logic [27:0] NATIVE_MAX_DEF = 28'h00F3FFF;
	typedef enum logic [5:0] {
		ST_IDLE   = 6'b000001,
		ST_LOAD   = 6'b000010,
		ST_WORDS  = 6'b000100,
		ST_ECC    = 6'b001000,
		ST_VERIFY = 6'b010000,
		ST_DONE   = 6'b100000
	} arce_state_t;
endpackage : arce_pkg
`default_nettype wire

//--- arce_addr_step.sv
// Address step: next LBA and remaining count, and the block-start decision.
// Assumes LBA addressing; a CHS host sees the same bits in the same registers.
`default_nettype none
module arce_addr_step
	import arce_pkg::*;
(
	input  wire logic [27:0] lba,
	input  wire logic [8:0]  remain,
	input  wire logic [7:0]  blockSize,
	input  wire logic [7:0]  inBlock,
	output logic      [27:0] nextLba,
	output logic      [8:0]  nextRemain,
	output logic      [7:0]  nextInBlock,
	output logic             blockStart
);
	assign nextLba     = lba + 28'h0000001;
	assign nextRemain  = remain - 9'h001;
	// The count wraps per block, so a short tail block falls out of the remaining count. see [RULE4]
	assign nextInBlock = (inBlock + 8'h01 >= blockSize) ? 8'h00 : inBlock + 8'h01;
	assign blockStart  = (inBlock == 8'h00);
endmodule : arce_addr_step
`default_nettype wire

//--- arce_read_engine.sv
// Read command engine: executes read, verify, long read, native max, recalibrate, sense.
// Assumes the task file latches a command with cmdValid and that the media side
// fills the sector buffer and reports status one handshake per sector.
`default_nettype none
module arce_read_engine
	import arce_pkg::*;
#(
	parameter logic [27:0] NATIVE_MAX = NATIVE_MAX_DEF
)
(
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        cmdValid,
	input  wire logic [7:0]  cmdCode,
	input  wire logic [27:0] cmdLba,
	input  wire logic [7:0]  cmdCount,
	input  wire logic        multiSet,
	input  wire logic        multiEnable,
	input  wire logic [7:0]  multiCount,
	input  wire logic        mediaDone,
	input  wire logic        mediaErr,
	input  wire logic        mediaCorr,
	input  wire logic [15:0] bufWord,
	input  wire logic        hostRead,
	output logic             mediaReq,
	output logic [27:0]      mediaLba,
	output logic             mediaNoEcc,
	output logic             busy,
	output logic             dataReq,
	output logic             intrq,
	output logic             errFlag,
	output logic [7:0]       errReg,
	output logic [27:0]      lbaOut,
	output logic [7:0]       countOut,
	output logic [15:0]      hostData,
	output logic             byteMode,
	output logic [7:0]       identMaxBlock
);
	arce_state_t state;
	logic [27:0] lba;
	logic [8:0]  remain;
	logic [7:0]  blockSize;
	logic [7:0]  inBlock;
	logic [8:0]  wordCnt;
	logic [2:0]  eccCnt;
	logic        isMulti;
	logic        isLong;
	logic        stopAfter;
	logic        pendErr;
	logic [7:0]  lastXerr;

	wire [27:0] stepLba;
	wire [8:0]  stepRemain;
	wire [7:0]  stepInBlock;
	wire        atBlockStart;
	wire        isRead    = cmdCode == OP_READ_SEC0 || cmdCode == OP_READ_SEC1;
	wire        isLongCmd = cmdCode == OP_READ_LONG0 || cmdCode == OP_READ_LONG1;
	wire        isVerify  = cmdCode == OP_VERIFY0 || cmdCode == OP_VERIFY1;
	wire        isMultCmd = cmdCode == OP_READ_MULTI;
	wire        isRecal   = cmdCode[7:4] == OP_RECAL_HI;
	// Block reads need a prior set-multiple and the mode enabled. see [RULE5]
	wire        multiBad  = isMultCmd && !(multiSet && multiEnable);
	// Zero count means a full 256 sector run. see [RULE8]
	wire [8:0]  fullCount = (cmdCount == 8'h00) ? SEC_FULL : {1'b0, cmdCount};
	// Block size clamped to the single supported block. see [RULE2]
	wire [7:0]  clampBlk  = (multiCount > MAX_BLOCK || multiCount == 8'h00) ? MAX_BLOCK
	                        : multiCount;
	wire        lastWord  = wordCnt == WORDS_PER_SEC - 9'h001;
	wire        lastSec   = remain == 9'h001;
	// Long reads have no correction check, so only plain reads see errors. see [RULE13]
	wire        hardErr   = mediaErr && !mediaCorr && !isLong;
	wire        startCmd  = state == ST_IDLE && cmdValid;

	arce_addr_step u_step (
		.lba        (lba),
		.remain     (remain),
		.blockSize  (blockSize),
		.inBlock    (inBlock),
		.nextLba    (stepLba),
		.nextRemain (stepRemain),
		.nextInBlock(stepInBlock),
		.blockStart (atBlockStart)
	);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state      <= ST_IDLE;
			lba        <= 28'h0000000;
			remain     <= 9'h000;
			blockSize  <= 8'h01;
			inBlock    <= 8'h00;
			wordCnt    <= 9'h000;
			eccCnt     <= 3'h0;
			isMulti    <= 1'b0;
			isLong     <= 1'b0;
			stopAfter  <= 1'b0;
			pendErr    <= 1'b0;
			lastXerr   <= XERR_NONE;
			mediaReq   <= 1'b0;
			mediaLba   <= 28'h0000000;
			mediaNoEcc <= 1'b0;
			busy       <= 1'b0;
			dataReq    <= 1'b0;
			intrq      <= 1'b0;
			errFlag    <= 1'b0;
			errReg     <= 8'h00;
			lbaOut     <= 28'h0000000;
			countOut   <= 8'h00;
			hostData   <= 16'h0000;
			byteMode   <= 1'b0;
			identMaxBlock <= MAX_BLOCK; // see [RULE2]
		end else begin
			identMaxBlock <= MAX_BLOCK;
			intrq    <= 1'b0;
			mediaReq <= 1'b0;
			unique case (state)
				ST_IDLE: begin
					if (cmdValid) begin
						busy      <= 1'b1;
						errFlag   <= 1'b0;
						errReg    <= 8'h00;
						lba       <= cmdLba; // see [RULE8]
						remain    <= isLongCmd ? 9'h001 : fullCount; // see [RULE13]
						isMulti   <= isMultCmd;
						isLong    <= isLongCmd;
						blockSize <= isMultCmd ? clampBlk : 8'h01;
						inBlock   <= 8'h00;
						stopAfter <= 1'b0;
						pendErr   <= 1'b0;
						if (multiBad) begin
							errFlag  <= 1'b1; // see [RULE5]
							errReg   <= ERR_BIT_ABRT;
							lastXerr <= XERR_ABORT; // see [RULE22]
							state    <= ST_DONE;
						end else if (isRead || isLongCmd || isMultCmd || isVerify) begin
							mediaReq   <= 1'b1;
							mediaLba   <= cmdLba;
							mediaNoEcc <= isLongCmd;
							state      <= isVerify ? ST_VERIFY : ST_LOAD; // see [RULE17]
						end else if (cmdCode == OP_NATIVE_MAX) begin
							lbaOut   <= NATIVE_MAX; // see [RULE15] see [RULE16]
							lastXerr <= XERR_NONE;
							state    <= ST_DONE;
						end else if (cmdCode == OP_SENSE) begin
							errReg <= lastXerr; // see [RULE20]
							state  <= ST_DONE;
						end else if (isRecal) begin
							lastXerr <= XERR_NONE; // see [RULE19]
							state    <= ST_DONE;
						end else begin
							errFlag  <= 1'b1;
							errReg   <= ERR_BIT_ABRT;
							lastXerr <= XERR_INVALID;
							state    <= ST_DONE;
						end
					end
				end
				ST_LOAD: begin
					if (mediaDone) begin
						lbaOut   <= lba; // see [RULE11] see [RULE12]
						countOut <= remain[7:0];
						wordCnt  <= 9'h000;
						eccCnt   <= 3'h0;
						byteMode <= 1'b0;
						busy     <= 1'b0;
						dataReq  <= 1'b1;
						// Errors are posted as the block opens; the block is still sent. see [RULE6]
						if (hardErr || (mediaErr && !isLong)) begin
							errFlag  <= 1'b1;
							errReg   <= hardErr ? ERR_BIT_UNC : 8'h00;
							lastXerr <= hardErr ? XERR_UNCORR : XERR_CORR; // see [RULE22]
						end else if (!pendErr) begin
							lastXerr <= XERR_NONE;
						end
						// Any posted error sticks, so a clean later sector cannot hide it.
						pendErr   <= pendErr || (mediaErr && !isLong); // see [RULE20]
						// Sector reads stop at the failing sector; block reads after its block. see [RULE9]
						stopAfter <= hardErr;
						// One interrupt per block, raised with data request. see [RULE1] see [RULE7]
						intrq     <= !isMulti || atBlockStart; // see [RULE10]
						state     <= ST_WORDS;
					end
				end
				ST_WORDS: begin
					if (hostRead) begin
						hostData <= bufWord; // see [RULE14]
						wordCnt  <= wordCnt + 9'h001;
						if (lastWord) begin
							if (isLong) begin
								byteMode <= 1'b1; // see [RULE14]
								state    <= ST_ECC;
							end else if (lastSec || (stopAfter && (!isMulti
							             || stepInBlock == 8'h00))) begin
								dataReq <= 1'b0;
								state   <= ST_IDLE;
							end else begin
								lba      <= stepLba;
								remain   <= stepRemain;
								inBlock  <= stepInBlock;
								mediaLba <= stepLba;
								mediaReq <= 1'b1;
								// Inside a block the next sector flows with data request held. see [RULE3]
								dataReq  <= isMulti && stepInBlock != 8'h00;
								busy     <= !(isMulti && stepInBlock != 8'h00);
								state    <= ST_LOAD;
							end
						end
					end
				end
				ST_ECC: begin
					if (hostRead) begin
						hostData <= {8'h00, bufWord[7:0]};
						eccCnt   <= eccCnt + 3'h1;
						if (eccCnt == ECC_BYTES - 3'h1) begin
							dataReq  <= 1'b0;
							byteMode <= 1'b0;
							state    <= ST_IDLE;
						end
					end
				end
				ST_VERIFY: begin
					if (mediaDone) begin
						lbaOut <= lba;
						if (hardErr) begin
							errFlag  <= 1'b1; // see [RULE18]
							errReg   <= ERR_BIT_UNC;
							lastXerr <= XERR_UNCORR;
							countOut <= remain[7:0];
							state    <= ST_DONE;
						end else if (lastSec) begin
							countOut <= 8'h00;
							lastXerr <= XERR_NONE;
							state    <= ST_DONE;
						end else begin
							lba      <= stepLba;
							remain   <= stepRemain;
							mediaLba <= stepLba;
							mediaReq <= 1'b1;
						end
					end
				end
				ST_DONE: begin
					busy  <= 1'b0; // see [RULE17] see [RULE23]
					intrq <= 1'b1;
					state <= ST_IDLE;
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	sequence s_verify_start;
		startCmd && isVerify && !multiBad;
	endsequence

	AST_VERIFY_NO_DRQ: assert property (@(posedge clk) disable iff (!arst_n) // see [RULE17]
		s_verify_start |=> (!dataReq && busy) throughout (state == ST_VERIFY)[*1])
		else $error("Verify raised data request.");
	AST_MULTI_ABORT: assert property (@(posedge clk) disable iff (!arst_n) // see [RULE5]
		startCmd && multiBad |=> errFlag && errReg == ERR_BIT_ABRT ##1 intrq && !busy)
		else $error("Block read without set-multiple not aborted.");
	AST_INTR_WITH_DRQ: assert property (@(posedge clk) disable iff (!arst_n) // see [RULE7]
		$rose(dataReq) |-> intrq && !busy)
		else $error("Data request rose without interrupt.");
	AST_SENSE: assert property (@(posedge clk) disable iff (!arst_n) // see [RULE20]
		startCmd && cmdCode == OP_SENSE |=> errReg == $past(lastXerr) && !errFlag)
		else $error("Sense did not return the previous code.");
	AST_NATIVE: assert property (@(posedge clk) disable iff (!arst_n) // see [RULE15]
		startCmd && cmdCode == OP_NATIVE_MAX |=> lbaOut == NATIVE_MAX ##1 intrq)
		else $error("Native max address wrong.");
	AST_RECAL: assert property (@(posedge clk) disable iff (!arst_n) // see [RULE23]
		startCmd && isRecal |=> ##1 intrq && !busy && !errFlag)
		else $error("Recalibrate did not finish cleanly.");
	AST_LONG_ONE: assert property (@(posedge clk) disable iff (!arst_n) // see [RULE13]
		startCmd && isLongCmd |=> remain == 9'h001 && mediaNoEcc)
		else $error("Long read not single sector.");
	AST_ZERO_256: assert property (@(posedge clk) disable iff (!arst_n) // see [RULE8]
		startCmd && isRead && cmdCount == 8'h00 |=> remain == SEC_FULL)
		else $error("Zero count not taken as 256.");
	AST_BLOCK_ONE: assert property (@(posedge clk) disable iff (!arst_n) // see [RULE2]
		blockSize == MAX_BLOCK && identMaxBlock == MAX_BLOCK)
		else $error("Block size above the supported limit.");

	sequence s_hard_fail;
		state == ST_LOAD && mediaDone && hardErr;
	endsequence

	sequence s_last_read;
		state == ST_WORDS && hostRead && lastWord && stopAfter && !isMulti && !isLong;
	endsequence

	AST_VERIFY_QUIET: assert property (@(posedge clk) disable iff (!arst_n) // see [RULE17]
		state == ST_VERIFY |-> !dataReq && busy)
		else $error("Data request seen during verify.");
	AST_WORDS_DRQ: assert property (@(posedge clk) disable iff (!arst_n) // see [RULE10]
		state == ST_WORDS |-> dataReq && !busy)
		else $error("Sector transfer without data request.");
	AST_FAIL_ADDR: assert property (@(posedge clk) disable iff (!arst_n) // see [RULE12]
		s_hard_fail |=> lbaOut == $past(lba) && errFlag && errReg == ERR_BIT_UNC)
		else $error("Failing sector address not reported.");
	AST_FAIL_STOP: assert property (@(posedge clk) disable iff (!arst_n) // see [RULE12]
		s_last_read |=> state == ST_IDLE && !dataReq)
		else $error("Sector read went on after an error.");
	AST_ECC_BYTES: assert property (@(posedge clk) disable iff (!arst_n) // see [RULE14]
		state == ST_ECC |-> byteMode && dataReq)
		else $error("Correction bytes sent outside byte mode.");
endmodule : arce_read_engine
`default_nettype wire

//--- arce_media_model.sv
// Media side model: answers each sector request after a random delay of 1 to 4 cycles.
// Assumes the engine asks for one sector at a time and holds mediaLba meanwhile.
`default_nettype none
module arce_media_model
	import arce_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        mediaReq,
	input  wire logic [27:0] mediaLba,
	input  wire logic        errOn,
	input  wire logic        errCorr,
	input  wire logic [27:0] errLba,
	output logic             mediaDone,
	output logic             mediaErr,
	output logic             mediaCorr,
	output logic [15:0]      bufWord
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [27:0] addr;
	int          waitN;
	logic        pend;
	initial begin
		pend = 1'b0;
		waitN = 0;
		forever begin
			@(negedge clk);
			bufWord = 16'($urandom);
			if (pend && waitN == 0) begin
				mediaDone = 1'b1;
				mediaErr = errOn && (addr === errLba);
				mediaCorr = errCorr;
				pend = 1'b0;
			end else begin
				// Status is junk between answers, so a stale sample cannot pass.
				mediaDone = 1'b0;
				{mediaErr, mediaCorr} = 2'($urandom);
			end
			if (mediaReq === 1'b1) begin
				pend = 1'b1;
				addr = mediaLba;
				waitN = $urandom_range(3, 0);
			end else if (waitN > 0) begin
				waitN--;
			end
		end
	end
endmodule : arce_media_model
`default_nettype wire

//--- arce_read_engine_tb_top.sv
// Self-checking bench for the read command engine with a media model behind it.
// Assumes the engine's hand-over timing: one command at a time, reads gated by dataReq.
`default_nettype none
module arce_read_engine_tb_top
	import arce_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [27:0] NMAX = 28'hA5C3E71;
	logic clk, arst_n, cmdValid, multiSet, multiEnable, mediaDone, mediaErr, mediaCorr;
	logic hostRead, mediaReq, mediaNoEcc, busy, dataReq, intrq, errFlag, byteMode;
	logic errOn, errCorr, rdPrev, drqPrev;
	logic [7:0]  cmdCode, cmdCount, multiCount, errReg, countOut, identMaxBlock;
	logic [27:0] cmdLba, mediaLba, lbaOut, errLba, a;
	logic [15:0] bufWord, hostData, rdWord;
	int mismatches, checks, nInt, nReq, nDrq, nWord, nByte, i;
	arce_read_engine #(.NATIVE_MAX(NMAX)) DUT (.clk(clk), .arst_n(arst_n),
		.cmdValid(cmdValid), .cmdCode(cmdCode), .cmdLba(cmdLba), .cmdCount(cmdCount),
		.multiSet(multiSet), .multiEnable(multiEnable), .multiCount(multiCount),
		.mediaDone(mediaDone), .mediaErr(mediaErr), .mediaCorr(mediaCorr),
		.bufWord(bufWord), .hostRead(hostRead), .mediaReq(mediaReq), .mediaLba(mediaLba),
		.mediaNoEcc(mediaNoEcc), .busy(busy), .dataReq(dataReq), .intrq(intrq),
		.errFlag(errFlag), .errReg(errReg), .lbaOut(lbaOut), .countOut(countOut),
		.hostData(hostData), .byteMode(byteMode), .identMaxBlock(identMaxBlock));
	arce_media_model media (.clk(clk), .mediaReq(mediaReq), .mediaLba(mediaLba),
		.errOn(errOn), .errCorr(errCorr), .errLba(errLba), .mediaDone(mediaDone),
		.mediaErr(mediaErr), .mediaCorr(mediaCorr), .bufWord(bufWord));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic chk(input logic [27:0] got, input logic [27:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic close_out;
		$display("checks=%0d mismatches=%0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : close_out
	// The host reads whenever dataReq stands, with no per-sector wait.
	task automatic run(input logic [7:0] op, input logic [27:0] lba, input logic [7:0] n);
		int k;
		nInt = 0;
		nReq = 0;
		nDrq = 0;
		nWord = 0;
		nByte = 0;
		@(negedge clk);
		{cmdValid, cmdCode, cmdLba, cmdCount} = {1'b1, op, lba, n};
		@(negedge clk);
		cmdValid = 1'b0;
		for (k = 0; k < 90000; k++) begin
			@(negedge clk);
			hostRead = dataReq;
			if (busy === 1'b0 && dataReq === 1'b0) break;
		end
		if (k == 90000) begin
			mismatches++;
			close_out();
		end else begin
			repeat (3) @(negedge clk);
		end
	endtask : run
	always @(posedge clk) begin
		nInt += (intrq === 1'b1);
		nReq += (mediaReq === 1'b1);
		if (dataReq === 1'b1 && drqPrev !== 1'b1) begin
			nDrq++;
			chk(28'(intrq), 28'h1);
		end
		if (hostRead && byteMode === 1'b1) nByte++;
		else if (hostRead) nWord++;
		if (rdPrev) chk(28'(hostData), 28'(rdWord));
		rdPrev <= hostRead;
		// Correction bytes come back in the low byte only.
		rdWord <= (byteMode === 1'b1) ? {8'h00, bufWord[7:0]} : bufWord;
		drqPrev <= dataReq;
	end
	initial begin
		void'($urandom(32'h56B26EAD));
		{arst_n, cmdValid, hostRead, errOn, errCorr, rdPrev, drqPrev} = 7'h00;
		{cmdCode, cmdCount, cmdLba, errLba} = 72'h0;
		{multiSet, multiEnable, multiCount} = {2'b11, 8'($urandom_range(8, 1))};
		repeat (10) @(posedge clk);
		@(negedge clk);
		arst_n = 1'b1;
		chk(28'(identMaxBlock), 28'(MAX_BLOCK));
		a = 28'($urandom_range(28'h0F00000));
		i = $urandom_range(4, 2);
		run({7'h10, 1'($urandom)}, a, 8'(i));
		chk(28'(nInt), 28'(i));
		chk(28'(nWord), 28'(i * 256));
		chk(lbaOut, a + 28'(i - 1));
		run(OP_READ_MULTI, a, 8'h03);
		chk(28'(nInt), 28'h3);
		chk(28'(nWord), 28'h300);
		for (i = 0; i < 2; i++) begin
			{multiSet, multiEnable} = {1'(i), 1'(!i)};
			run(OP_READ_MULTI, a, 8'h02);
			chk(28'({errReg, 8'(nReq)}), 28'({ERR_BIT_ABRT, 8'h0}));
			run(OP_SENSE, a, 8'h0);
			chk(28'(errReg), 28'(XERR_ABORT));
		end
		{multiSet, multiEnable, errOn, errLba} = {3'b111, a + 28'h1};
		run(OP_READ_SEC0, a, 8'h03);
		chk(28'({nInt[3:0], nWord[15:0]}), 28'({4'h2, 16'h200}));
		chk(lbaOut, a + 28'h1);
		chk(28'(errReg), 28'(ERR_BIT_UNC));
		run(OP_SENSE, a, 8'h0);
		chk(28'(errReg), 28'(XERR_UNCORR));
		errCorr = 1'b1;
		run(OP_READ_MULTI, a, 8'h03);
		chk(28'(nInt), 28'h3);
		chk(lbaOut, a + 28'h2);
		chk(28'(errFlag), 28'h1);
		run(OP_SENSE, a, 8'h0);
		chk(28'(errReg), 28'(XERR_CORR));
		errCorr = 1'b0;
		run(OP_VERIFY1, a, 8'h04);
		chk(28'({nDrq[3:0], nInt[3:0]}), 28'({4'h0, 4'h1}));
		chk(28'(countOut), 28'h3);
		chk(lbaOut, a + 28'h1);
		errOn = 1'b0;
		run(OP_VERIFY0, a, 8'h00);
		chk(28'(nReq), 28'(SEC_FULL));
		chk(lbaOut, a + 28'hFF);
		// A planted fault must go unnoticed, since long reads skip correction.
		{errOn, errLba} = {1'b1, a};
		run({7'h11, 1'($urandom)}, a, 8'h01);
		chk(28'({nWord[11:0], nByte[3:0]}), 28'({12'h100, 4'h4}));
		chk(28'(errFlag), 28'h0);
		run(OP_NATIVE_MAX, a, 8'h0);
		chk(lbaOut, NMAX);
		for (i = 0; i < 16; i++) begin
			run({OP_RECAL_HI, 4'(i)}, a, 8'h0);
			chk(28'({errFlag, 4'(nInt)}), 28'h1);
		end
		close_out();
	end
endmodule : arce_read_engine_tb_top
`default_nettype wire
